// [logic/spif_top.sv]
module spif_top import spif_pkg::*; #(
   parameter int LVL_W = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Classic Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Shift engine events and mode
   input wire logic [1:0] mode,
   input wire spif_rx_ev_t rx_ev,
   input wire logic tx_done,
   input wire logic [LVL_W-1:0] rx_level,
   input wire logic [LVL_W-1:0] tx_level,
   // Field outputs to the rest of the port
   output logic fifo_enable,
   output logic [1:0] receive_threshold_field,
   output logic [1:0] transmit_threshold_field,
   output logic [7:0] serial_port_control,
   output logic irq
);
   // ************************************************************
   // Threshold decode
   // ************************************************************
   // Code n selects a level of n+1 entries; coarse but monotone
   function automatic logic at_thr(input logic [LVL_W-1:0] lvl,
                                   input logic [1:0] code);
      at_thr = lvl >= LVL_W'({1'b0, code} + 3'd1);
   endfunction

   logic [7:0] fifo_control_register;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic ack_q;
   spif_mode_t cur_mode;
   assign cur_mode = spif_mode_t'(mode);
   assign fifo_enable = fifo_control_register[SPIF_B_FEN];
   assign receive_threshold_field =
      fifo_control_register[SPIF_B_RXT +: 2];
   assign transmit_threshold_field =
      fifo_control_register[SPIF_B_TXT +: 2];

   // ************************************************************
   // Receive and transmit set conditions
   // ************************************************************
   wire qual = serial_port_control[SPIF_B_QUAL];
   // Qualifier: mode 1 needs a valid stop, modes 2/3 need address bit
   wire qual_ok = !qual || ((cur_mode == SPIF_M1) ? rx_ev.ninth
                                                  : rx_ev.addr_match);
   wire rx_lvl_ok = !fifo_enable ||
                    at_thr(rx_level, receive_threshold_field);
   wire rx_set_m0 = rx_ev.done && cur_mode == SPIF_M0;
   wire rx_set_mx = rx_ev.done && cur_mode != SPIF_M0 &&
                    qual_ok && rx_lvl_ok;
   wire rx_set = rx_set_m0 || rx_set_mx;
   wire tx_set = tx_done && (!fifo_enable ||
                 at_thr(tx_level, transmit_threshold_field));
   wire ninth_ld = rx_set_mx && (cur_mode != SPIF_M1 || !qual);

   // ************************************************************
   // Bus decode
   // ************************************************************
   wire req = wb_cyc_i && wb_stb_i && !ack_q;
   wire hit_sctl = wb_adr_i == SPIF_ADDR_SCTL;
   wire hit_fifo = wb_adr_i == SPIF_ADDR_FIFO;
   wire hit_ist = wb_adr_i == SPIF_ADDR_IST;
   wire hit_imsk = wb_adr_i == SPIF_ADDR_IMSK;
   wire hit_any = hit_sctl || hit_fifo || hit_ist || hit_imsk;
   wire wr0 = req && wb_we_i && wb_sel_i[0];
   wire wr_sctl = wr0 && hit_sctl;
   wire rd_ist = req && !wb_we_i && hit_ist;
   logic [7:0] rd_mux;
   assign rd_mux = hit_sctl ? serial_port_control :
                   hit_fifo ? fifo_control_register :
                   hit_ist ? {6'h00, irq_status} :
                   hit_imsk ? {6'h00, irq_mask} : 8'h00;

   // Software writes flags as plain bits; a set event wins the cycle
   logic [7:0] next_sctl;
   always_comb begin
      next_sctl = wr_sctl ? wb_dat_i[7:0] : serial_port_control;
      if (ninth_ld) begin
         next_sctl[SPIF_B_NINTH] = rx_ev.ninth;
      end
      if (rx_set) begin
         next_sctl[SPIF_B_RXF] = 1'b1;
      end
      if (tx_set) begin
         next_sctl[SPIF_B_TXF] = 1'b1;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         serial_port_control <= SPIF_SCTL_RST;
         fifo_control_register <= SPIF_FIFO_RST;
         irq_mask <= SPIF_IRQ_RST;
      end else begin
         serial_port_control <= next_sctl;
         if (wr0 && hit_fifo) begin
            fifo_control_register <= wb_dat_i[7:0];
         end
         if (wr0 && hit_imsk) begin
            irq_mask <= wb_dat_i[1:0];
         end
      end
   end

   // Read clears status, but an event in the same cycle survives
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         irq_status <= SPIF_IRQ_RST;
      end else begin
         irq_status <= (rd_ist ? 2'b00 : irq_status) | {tx_set, rx_set};
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack_q <= req && hit_any;
         wb_err_o <= req && !hit_any;
         wb_dat_o <= {24'h00_0000, rd_mux};
      end
   end
   assign wb_ack_o = ack_q;
   assign irq = |(irq_status & irq_mask);
endmodule

// [logic/spif_pkg.sv]
// What this block does
// - Any reset loads control register with zero
// - Mode 0: receive flag on every byte
// - Other modes: qualifier gates receive flag
// - FIFO on: receive flag at threshold level in modes 1-3
// - Mode 0: set after eighth data bit
// - Mode 1: set after stop bit sample
// - Modes 2,3: set after ninth bit sample
// - FIFO off: transmit flag per sent byte
// - FIFO on: transmit flag at threshold
// - Ninth bit holds bit9, or stop level in mode 1 only with qualifier off
package spif_pkg;
   // ************************************************************
   // Register map (byte addresses on the bus)
   // ************************************************************
   localparam logic [7:0] SPIF_SCTL_IDX = 8'h06;
   localparam logic [9:0] SPIF_ADDR_SCTL = {SPIF_SCTL_IDX, 2'b00};
   localparam logic [9:0] SPIF_ADDR_FIFO = 10'h020;
   localparam logic [9:0] SPIF_ADDR_IST = 10'h024;
   localparam logic [9:0] SPIF_ADDR_IMSK = 10'h028;
   localparam logic [7:0] SPIF_SCTL_RST = 8'h00;
   localparam logic [7:0] SPIF_FIFO_RST = 8'h00;
   localparam logic [1:0] SPIF_IRQ_RST = 2'h0;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int SPIF_B_RXF = 0;
   localparam int SPIF_B_TXF = 1;
   localparam int SPIF_B_NINTH = 2;
   localparam int SPIF_B_QUAL = 5;
   localparam int SPIF_B_FEN = 0;
   localparam int SPIF_B_RXT = 2;
   localparam int SPIF_B_TXT = 4;
   typedef enum logic [1:0] {
      SPIF_M0 = 2'h0,
      SPIF_M1 = 2'h1,
      SPIF_M2 = 2'h3,
      SPIF_M3 = 2'h2
   } spif_mode_t;
   typedef struct packed {
      logic done;
      logic ninth;
      logic addr_match;
   } spif_rx_ev_t;
endpackage

// [test/spif_assertions.sv]
module spif_assertions import spif_pkg::*; (
   // Watched ports
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic [1:0] mode,
   input wire spif_rx_ev_t rx_ev,
   input wire logic tx_done,
   input wire logic fifo_enable,
   input wire logic [7:0] serial_port_control
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   wire logic [7:0] sc = serial_port_control;
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence
   sequence s_rx;
      rx_ev.done && !fifo_enable && !sc[5];
   endsequence
   a_bus_answer: assert property (s_take |=> wb_ack_o ^ wb_err_o)
      else $error("no bus answer");
   a_reset_zero: assert property ($rose(nrst) |-> sc == SPIF_SCTL_RST)
      else $error("bad reset value");
   a_rx_mode0: assert property (
      rx_ev.done && mode == 2'h0 |=> sc[0])
      else $error("mode 0 receive flag missing");
   a_rx_plain: assert property (s_rx |=> sc[0])
      else $error("receive flag missing");
   a_tx_plain: assert property (tx_done && !fifo_enable |=> sc[1])
      else $error("transmit flag missing");
   a_rx_cause: assert property ($rose(sc[0]) |-> $past(rx_ev.done))
      else $error("receive flag without event");
   a_flag_sticky: assert property (!(wb_cyc_i && wb_stb_i && wb_we_i)
      |=> (sc[1:0] & $past(sc[1:0])) == $past(sc[1:0]))
      else $error("flag dropped");
   a_ninth_load: assert property (
      s_rx ##0 mode[1] |=> sc[2] == $past(rx_ev.ninth))
      else $error("ninth bit wrong");
endmodule
bind spif_top spif_assertions u_chk (.*);

// [test/spif_peer.sv]
module spif_peer import spif_pkg::*; (
   // Events towards the port
   input wire logic clk_sys,
   output spif_rx_ev_t rx_ev,
   output logic tx_done
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {rx_ev, tx_done} = '0;
   // Wait w cycles: a slow or a prompt far end
   task automatic send(input logic r, n, a, input int w);
      repeat (w) @(posedge clk_sys);
      rx_ev <= '{r, n, a};
      tx_done <= !r;
      @(posedge clk_sys);
      rx_ev <= '{1'b0, !n, !a};
      tx_done <= 1'b0;
   endtask
endmodule

// [test/tb.sv]
module tb import spif_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, nrst, cyc, we, tx_done, ack, err, fen, irq, m0, m1, e;
   logic [1:0] mode, rxt, txt;
   logic [3:0] rxl, txl;
   logic [9:0] adr;
   logic [31:0] dat, rd, q, r, s = 32'h0000E0E7;
   logic [7:0] sc;
   spif_rx_ev_t rx_ev;
   int errors, tests_run, cnt;
   spif_top DUT (.clk_sys, .nrst, .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(err), .mode, .rx_ev,
      .tx_done, .rx_level(rxl), .tx_level(txl), .fifo_enable(fen),
      .receive_threshold_field(rxt), .transmit_threshold_field(txt),
      .serial_port_control(sc), .irq);
   spif_peer P (.clk_sys, .rx_ev, .tx_done);
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h000000, d};
      do @(posedge clk_sys); while (!(ack || err));
      q = rd;
      e = err;
      cyc <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Forty rounds need about 1000 cycles
   always @(posedge clk_sys) begin
      cnt <= cnt + 1;
      if (cnt == 5000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      {nrst, cyc, we, mode, rxl, txl, adr, dat, cnt} = '0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      wb(0, SPIF_ADDR_SCTL, 8'h00);
      chk("reset", SPIF_SCTL_RST, q);
      wb(0, 10'h3F0, 8'h00);
      chk("unmapped", 0, q);
      chk("unmapped err", 1, e);
      fork
         wb(1, SPIF_ADDR_SCTL, 8'h00);
         P.send(1, 0, 0, 0);
      join
      wb(0, SPIF_ADDR_SCTL, 8'h00);
      chk("set wins", 1, q[0]);
      for (int i = 0; i < 40; i++) begin
         s = xs(s);
         r = s;
         mode <= r[1:0];
         rxl <= r[7:4];
         txl <= r[11:8];
         wb(1, SPIF_ADDR_FIFO, {2'h0, r[17:14], 1'h0, r[12]});
         chk("fifo fields", {r[17:14], r[12]}, {txt, rxt, fen});
         wb(1, SPIF_ADDR_SCTL, {2'h0, r[18], 5'h00});
         wb(1, SPIF_ADDR_IMSK, {6'h00, r[20:19]});
         wb(0, SPIF_ADDR_IST, 8'h00);
         P.send(1, r[21], r[22], r[25:23]);
         P.send(0, 0, 0, r[27:26]);
         m0 = r[1:0] == 0 || ((!r[18] || (r[1:0] == 1 ? r[21] : r[22]))
            && (!r[12] || r[7:4] > r[15:14]));
         m1 = !r[12] || r[11:8] > r[17:16];
         wb(0, SPIF_ADDR_SCTL, 8'h00);
         chk("flags", {m1, m0}, q[1:0]);
         chk("irq", (m0 & r[19]) | (m1 & r[20]), irq);
         wb(0, SPIF_ADDR_IST, 8'h00);
         chk("status", {m1, m0}, q[1:0]);
         chk("irq cleared", 0, irq);
         $display("test %0d done", i);
      end
      print_verdict();
   end
endmodule
